/* rtl/shrhp_consts.svh */
`ifndef SHRHP_CONSTS_SVH
`define SHRHP_CONSTS_SVH
// ----------------------------------------
// widths and sizes
// ----------------------------------------
`define SHRHP_DATA_W 8
`define SHRHP_ADDR_W 7
`define SHRHP_DEPTH 128
// ----------------------------------------
// host map: top two locations are registers
// ----------------------------------------
`define SHRHP_IRQ_ADDR 7'h7f
`define SHRHP_IO_ADDR 7'h7e
// ----------------------------------------
// bus style strap values
// ----------------------------------------
`define SHRHP_STYLE_SINGLE 1'b0
`define SHRHP_STYLE_SPLIT 1'b1
// ----------------------------------------
// host strobe hold, cycles
// ----------------------------------------
`define SHRHP_HOLD_NS 40
`define SHRHP_CLK_NS 10
`define SHRHP_HOLD_CYC ((`SHRHP_HOLD_NS + `SHRHP_CLK_NS - 1) / `SHRHP_CLK_NS)
`define SHRHP_RESET_BYTE 8'h00
`endif

/* rtl/shrhp_pkg.sv */
package shrhp_pkg;
    typedef logic [7:0] shrhp_byte_t;
    typedef logic [6:0] shrhp_addr_t;
    typedef enum logic [1:0] {
        SHRHP_H_IDLE = 2'b00,
        SHRHP_H_STROBE = 2'b01,
        SHRHP_H_RELEASE = 2'b10
    } shrhp_hstate_t;
endpackage

/* rtl/shrhp_if.sv */
`timescale 1ns/100ps
interface shrhp_if;
    logic [6:0] host_address_bus;
    logic [7:0] host_data_from_host;
    logic host_data_host_oe;
    logic [7:0] host_data_from_dev;
    logic host_data_dev_oe;
    logic host_data_strobe_n;
    logic host_direction;
    logic host_select_n;
    logic bus_style_select;
    logic host_irq_oe;
    wire [7:0] host_data_bus = host_data_dev_oe ? host_data_from_dev :
        host_data_host_oe ? host_data_from_host : 8'hff;
    wire host_irq_n = ~host_irq_oe;
    // in split style host_data_strobe_n is the read strobe, host_direction the write strobe
    modport device (
        input host_address_bus, host_data_bus, host_data_strobe_n, host_direction,
        input host_select_n, bus_style_select,
        output host_data_from_dev, host_data_dev_oe, host_irq_oe
    );
    modport host (
        input host_data_bus, host_irq_n,
        output host_address_bus, host_data_from_host, host_data_host_oe,
        output host_data_strobe_n, host_direction, host_select_n, bus_style_select
    );
endinterface

/* rtl/shrhp_ram.sv */
`timescale 1ns/100ps
`include "shrhp_consts.svh"
module shrhp_ram (
    input wire logic i_ref_clk,
    input wire logic i_a_we,
    input wire logic [6:0] i_a_addr,
    input wire logic [7:0] i_a_wdata,
    output logic [7:0] o_a_rdata,
    input wire logic i_b_we,
    input wire logic [6:0] i_b_addr,
    input wire logic [7:0] i_b_wdata,
    output logic [7:0] o_b_rdata,
    output logic o_b_lost
);
    logic [7:0] mem [0:`SHRHP_DEPTH-1];
    // ----------------------------------------
    // shared array, host port a wins
    // ----------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (i_a_we) begin
            mem[i_a_addr] <= i_a_wdata;
        end else if (i_b_we) begin
            mem[i_b_addr] <= i_b_wdata;
        end
        o_a_rdata <= mem[i_a_addr];
        o_b_rdata <= mem[i_b_addr];
        o_b_lost <= i_a_we & i_b_we & (i_a_addr == i_b_addr);
    end
endmodule

/* rtl/shrhp_device.sv */
`timescale 1ns/100ps
`include "shrhp_consts.svh"
// Function
// - 8-bit data bus, released when idle
// - host strobes asynchronous, synchronised
// - 7-bit address picks RAM or registers
// - 128 by 8 shared memory
// - strap picks single or split strobes
// - single style: strobe low starts exchange
// - single style: direction line marks read/write
// - split style: read strobe low reads
// - split style: write strobe low writes
// - respond only while select low
// - open-drain interrupt, host clears it
module shrhp_device (
    input wire logic i_ref_clk,
    input wire logic i_arst_n,
    shrhp_if.device bus,
    input wire logic i_core_we,
    input wire logic [6:0] i_core_addr,
    input wire logic [7:0] i_core_wdata,
    output logic [7:0] o_core_rdata,
    output logic o_core_lost,
    input wire logic i_core_irq,
    input wire logic [7:0] i_io_in,
    output logic [7:0] o_io_out
);
    typedef struct packed {
        logic [11:0] s1;
        logic [11:0] s2;
        logic busy;
        logic rd;
        logic oe;
        logic irq;
        logic [7:0] io;
        logic [6:0] addr;
        logic [7:0] dout;
        logic ram_rd;
        logic [7:0] d1;
        logic [7:0] d2;
    } shrhp_dev_t;
    shrhp_dev_t r, n;
    logic [6:0] a_s;
    logic [7:0] d_s;
    logic cs, ds, dir, style, rd_act, wr_act, act, wr_ram;
    logic [7:0] ram_q;
    assign a_s = r.s2[6:0];
    assign d_s = r.d2;
    assign cs = r.s2[7];
    assign ds = r.s2[8];
    assign dir = r.s2[9];
    assign style = r.s2[10];
    // ----------------------------------------
    // strobe decode
    // ----------------------------------------
    always_comb begin
        rd_act = 1'b0;
        wr_act = 1'b0;
        if (style == `SHRHP_STYLE_SINGLE) begin
            rd_act = ~ds & dir;
            wr_act = ~ds & ~dir;
        end else begin
            rd_act = ~ds;
            wr_act = ~dir;
        end
    end
    assign act = ~cs & (rd_act | wr_act);
    assign wr_ram = act & ~r.busy & wr_act & (a_s < `SHRHP_IO_ADDR);
    shrhp_ram u_ram (
        .i_ref_clk(i_ref_clk),
        .i_a_we(wr_ram),
        .i_a_addr(a_s),
        .i_a_wdata(d_s),
        .o_a_rdata(ram_q),
        .i_b_we(i_core_we),
        .i_b_addr(i_core_addr),
        .i_b_wdata(i_core_wdata),
        .o_b_rdata(o_core_rdata),
        .o_b_lost(o_core_lost)
    );
    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        n = r;
        n.s1 = {1'b0, bus.bus_style_select, bus.host_direction, bus.host_data_strobe_n,
            bus.host_select_n, bus.host_address_bus};
        n.s2 = r.s1;
        n.d1 = bus.host_data_bus;
        n.d2 = r.d1;
        n.ram_rd = 1'b0;
        if (i_core_irq) begin
            n.irq = 1'b1;
        end
        if (!act) begin
            n.busy = 1'b0;
            n.oe = 1'b0;
        end else if (!r.busy) begin
            n.busy = 1'b1;
            n.addr = a_s;
            n.rd = rd_act;
            if (rd_act) begin
                n.oe = 1'b1;
                if (a_s == `SHRHP_IRQ_ADDR) begin
                    n.dout = {7'h00, r.irq};
                end else if (a_s == `SHRHP_IO_ADDR) begin
                    n.dout = i_io_in;
                end else begin
                    n.ram_rd = 1'b1;
                end
            end else if (a_s == `SHRHP_IRQ_ADDR) begin
                // host write clears, core set wins
                n.irq = i_core_irq;
            end else if (a_s == `SHRHP_IO_ADDR) begin
                n.io = d_s;
            end
        end
        if (r.ram_rd) begin
            n.dout = ram_q;
        end
    end
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            r <= '0;
            r.s1 <= 12'hfff;
            r.s2 <= 12'hfff;
        end else begin
            r <= n;
        end
    end
    assign bus.host_data_from_dev = r.dout;
    assign bus.host_data_dev_oe = r.oe;
    assign bus.host_irq_oe = r.irq;
    assign o_io_out = r.io;
endmodule

/* rtl/shrhp_host.sv */
`timescale 1ns/100ps
`include "shrhp_consts.svh"
module shrhp_host (
    input wire logic i_ref_clk,
    input wire logic i_arst_n,
    shrhp_if.host bus,
    input wire logic i_style,
    input wire logic i_req,
    input wire logic i_write,
    input wire logic [6:0] i_addr,
    input wire logic [7:0] i_wdata,
    output logic o_busy,
    output logic o_done,
    output logic [7:0] o_rdata,
    output logic o_irq
);
    typedef struct packed {
        shrhp_pkg::shrhp_hstate_t st;
        logic [7:0] cnt;
        logic wr;
        logic [6:0] addr;
        logic [7:0] wd;
        logic [7:0] rd;
        logic done;
        logic cs_n;
        logic stb;
        logic i1;
        logic i2;
    } shrhp_host_t;
    shrhp_host_t r, n;
    always_comb begin
        n = r;
        n.done = 1'b0;
        n.i1 = ~bus.host_irq_n;
        n.i2 = r.i1;
        case (r.st)
            shrhp_pkg::SHRHP_H_IDLE: begin
                if (i_req) begin
                    n.st = shrhp_pkg::SHRHP_H_STROBE;
                    n.wr = i_write;
                    n.addr = i_addr;
                    n.wd = i_wdata;
                    n.cs_n = 1'b0;
                    n.stb = 1'b1;
                    n.cnt = 8'h00;
                end
            end
            shrhp_pkg::SHRHP_H_STROBE: begin
                n.cnt = r.cnt + 8'h01;
                if (r.cnt == 8'(`SHRHP_HOLD_CYC + 6)) begin
                    n.rd = bus.host_data_bus;
                    n.stb = 1'b0;
                    n.cs_n = 1'b1;
                    n.cnt = 8'h00;
                    n.st = shrhp_pkg::SHRHP_H_RELEASE;
                end
            end
            default: begin
                n.cnt = r.cnt + 8'h01;
                if (r.cnt == 8'h06) begin
                    n.done = 1'b1;
                    n.st = shrhp_pkg::SHRHP_H_IDLE;
                end
            end
        endcase
    end
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            r <= '0;
            r.cs_n <= 1'b1;
        end else begin
            r <= n;
        end
    end
    assign bus.bus_style_select = i_style;
    assign bus.host_select_n = r.cs_n;
    assign bus.host_address_bus = r.addr;
    assign bus.host_data_from_host = r.wd;
    assign bus.host_data_host_oe = r.stb & r.wr;
    assign bus.host_data_strobe_n = (i_style == `SHRHP_STYLE_SINGLE) ? ~r.stb : ~(r.stb & ~r.wr);
    assign bus.host_direction = (i_style == `SHRHP_STYLE_SINGLE) ? ~r.wr : ~(r.stb & r.wr);
    assign o_busy = r.st != shrhp_pkg::SHRHP_H_IDLE;
    assign o_done = r.done;
    assign o_rdata = r.rd;
    assign o_irq = r.i2;
endmodule

/* verif/shrhp_asserts.sv */
`timescale 1ns/100ps
module shrhp_asserts (
    input wire logic i_ref_clk,
    input wire logic i_arst_n,
    input wire logic [6:0] host_address_bus,
    input wire logic host_data_host_oe,
    input wire logic host_data_dev_oe,
    input wire logic host_data_strobe_n,
    input wire logic host_select_n,
    input wire logic bus_style_select,
    input wire logic host_irq_oe
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_arst_n);
    // ----
    // wire checks
    // ----
    property p_no_fight;
        !(host_data_dev_oe && host_data_host_oe);
    endproperty
    a_no_fight: assert property (p_no_fight)
        else $error("both ends drive data");
    property p_release;
        $rose(host_select_n) |-> ##[0:5] !host_data_dev_oe;
    endproperty
    a_release: assert property (p_release)
        else $error("data not released");
    property p_drive_cause;
        $rose(host_data_dev_oe) |-> !host_select_n && !host_data_strobe_n;
    endproperty
    a_drive_cause: assert property (p_drive_cause)
        else $error("drive without strobe and select");
    property p_idle;
        host_select_n [*6] |-> !host_data_dev_oe;
    endproperty
    a_idle: assert property (p_idle)
        else $error("drive while unselected");
    property p_split_answer;
        bus_style_select && !host_select_n && $fell(host_data_strobe_n)
            |-> ##[1:8] host_data_dev_oe;
    endproperty
    a_split_answer: assert property (p_split_answer)
        else $error("split read not answered");
    property p_addr_stable;
        !host_select_n && !$past(host_select_n) |-> $stable(host_address_bus);
    endproperty
    a_addr_stable: assert property (p_addr_stable)
        else $error("address moved in cycle");
    property p_style_stable;
        !host_select_n && !$past(host_select_n) |-> $stable(bus_style_select);
    endproperty
    a_style_stable: assert property (p_style_stable)
        else $error("style moved in cycle");
    property p_irq_clear;
        $fell(host_irq_oe) |-> host_address_bus == 7'h7f;
    endproperty
    a_irq_clear: assert property (p_irq_clear)
        else $error("interrupt dropped without host");
endmodule

/* verif/tb_top.sv */
`timescale 1ns/100ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin num_errors++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic h_style = 1'b0;
    logic h_req = 1'b0;
    logic h_wr = 1'b0;
    logic [6:0] h_addr = 7'h00;
    logic [7:0] h_wdata = 8'h00;
    logic h_busy;
    logic h_done;
    logic [7:0] h_rdata;
    logic h_irq;
    logic c_we = 1'b0;
    logic [6:0] c_addr = 7'h00;
    logic [7:0] c_wdata = 8'h00;
    logic [7:0] c_rdata;
    logic c_lost;
    logic c_irq = 1'b0;
    logic [7:0] io_out;
    logic lost_seen = 1'b0;
    logic [7:0] rd;
    logic [7:0] v;
    int num_errors = 0;
    int comparisons = 0;
    shrhp_if bus_if ();
    always #5 clk = ~clk;
    always @(posedge clk) if (c_lost === 1'b1) lost_seen <= 1'b1;
    shrhp_device shrhp_device_inst (.i_ref_clk(clk), .i_arst_n(arst_n), .bus(bus_if.device),
        .i_core_we(c_we), .i_core_addr(c_addr), .i_core_wdata(c_wdata), .o_core_rdata(c_rdata),
        .o_core_lost(c_lost), .i_core_irq(c_irq), .i_io_in(8'h5a), .o_io_out(io_out));
    shrhp_host shrhp_host_inst (.i_ref_clk(clk), .i_arst_n(arst_n), .bus(bus_if.host),
        .i_style(h_style), .i_req(h_req), .i_write(h_wr), .i_addr(h_addr), .i_wdata(h_wdata),
        .o_busy(h_busy), .o_done(h_done), .o_rdata(h_rdata), .o_irq(h_irq));
    shrhp_asserts shrhp_asserts_inst (.i_ref_clk(clk), .i_arst_n(arst_n),
        .host_address_bus(bus_if.host_address_bus), .host_data_host_oe(bus_if.host_data_host_oe),
        .host_data_dev_oe(bus_if.host_data_dev_oe), .host_data_strobe_n(bus_if.host_data_strobe_n),
        .host_select_n(bus_if.host_select_n), .bus_style_select(bus_if.bus_style_select),
        .host_irq_oe(bus_if.host_irq_oe));
    // ----
    // tasks
    // ----
    task automatic report_and_stop;
        if (num_errors == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic hop(input logic w, input logic [6:0] a, input logic [7:0] d);
        int n;
        @(posedge clk);
        #1;
        h_req = 1'b1;
        h_wr = w;
        h_addr = a;
        h_wdata = d;
        @(posedge clk);
        #1;
        h_req = 1'b0;
        n = 0;
        while (h_done !== 1'b1 && n < 100) begin
            @(negedge clk);
            n++;
        end
        if (n >= 100) num_errors++;
        rd = h_rdata;
    endtask
    task automatic cwr(input logic [6:0] a, input logic [7:0] d);
        @(posedge clk);
        #1;
        c_we = 1'b1;
        c_addr = a;
        c_wdata = d;
        @(posedge clk);
        #1;
        c_we = 1'b0;
    endtask
    task automatic crd(input logic [6:0] a);
        @(posedge clk);
        #1;
        c_addr = a;
        repeat (2) @(posedge clk);
        @(negedge clk);
        rd = c_rdata;
    endtask
    // ----
    // tests
    // ----
    initial begin
        repeat (12) @(posedge clk);
        #1 arst_n = 1'b1;
        for (int s = 0; s < 2; s++) begin
            h_style = s[0];
            v = 8'ha5 + 8'(s);
            hop(1'b1, 7'h00, v);
            hop(1'b1, 7'h7d, ~v);
            hop(1'b0, 7'h00, 8'h00);
            `CHK(rd, v)
            hop(1'b0, 7'h7d, 8'h00);
            `CHK(rd, ~v)
            crd(7'h7d);
            `CHK(rd, ~v)
            cwr(7'h20, v ^ 8'h3c);
            hop(1'b0, 7'h20, 8'h00);
            `CHK(rd, v ^ 8'h3c)
            hop(1'b1, 7'h7e, v ^ 8'hff);
            `CHK(io_out, v ^ 8'hff)
            hop(1'b0, 7'h7e, 8'h00);
            `CHK(rd, 8'h5a)
            cwr(7'h00, 8'h00);
            c_irq = 1'b1;
            @(posedge clk);
            #1 c_irq = 1'b0;
            repeat (6) @(negedge clk);
            `CHK(bus_if.host_irq_n, 1'b0)
            `CHK(h_irq, 1'b1)
            hop(1'b0, 7'h7f, 8'h00);
            `CHK(rd[0], 1'b1)
            hop(1'b1, 7'h7f, 8'h00);
            repeat (6) @(negedge clk);
            `CHK(bus_if.host_irq_n, 1'b1)
            `CHK(h_irq, 1'b0)
            `CHK(bus_if.host_data_dev_oe, 1'b0)
        end
        fork
            begin
                @(posedge clk);
                #1;
                c_we = 1'b1;
                c_addr = 7'h10;
                c_wdata = 8'h11;
                @(negedge bus_if.host_select_n);
                repeat (3) @(posedge clk);
                #1 c_we = 1'b0;
            end
            hop(1'b1, 7'h10, 8'hee);
        join
        `CHK(lost_seen, 1'b1)
        crd(7'h10);
        `CHK(rd, 8'hee)
        report_and_stop;
    end
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        report_and_stop;
    end
endmodule
